//--- pkg/wdtu_pkg.sv
package wdtu_pkg;

  // apb map
  localparam logic [7:0]  ADDR_CONTROL   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h04;
  localparam logic [7:0]  ADDR_COUNT     = 8'h08;

  // control register fields
  localparam int          BIT_IDLE_KEEP  = 7;
  localparam int          TSEL_LSB       = 4;
  localparam int          KEY_LSB        = 0;
  localparam logic [7:0]  CONTROL_RESET  = 8'h7A;
  localparam logic [3:0]  KEY_DISABLE    = 4'hA;

  // status register fields
  localparam int          BIT_TIMEOUT    = 0;
  localparam int          BIT_ENABLED    = 1;
  localparam int          BIT_LAST_PAIR  = 2;

  // timeout base: code 000 gives 2^8 source periods
  localparam int          TIMEOUT_BASE_LOG2 = 8;
  localparam int          COUNT_W        = 16;

  // system clock divided by four
  localparam int          SYS_DIV        = 4;
  localparam logic [1:0]  SYS_DIV_LAST   = 2'h3;

  // power modes seen by the watchdog
  typedef enum logic [1:0] {
    WDTU_MODE_NORMAL   = 2'b00,
    WDTU_MODE_SLEEP    = 2'b01,
    WDTU_MODE_IDLE_OFF = 2'b10,
    WDTU_MODE_IDLE_ON  = 2'b11
  } wdtu_mode_t;

  // instruction strobes from the processor core
  typedef struct packed {
    logic clear_single;
    logic clear_first_of_pair;
    logic clear_second_of_pair;
    logic halt;
  } wdtu_instr_t;

  // build-time options
  typedef struct packed {
    logic src_is_sub;
    logic sub_is_crystal;
    logic cfg_enable;
    logic paired_style;
  } wdtu_opts_t;

  // reset requests toward the core
  typedef struct packed {
    logic device_reset;
    logic pc_sp_clear;
  } wdtu_reset_t;

endpackage

//--- hw/wdtu_top.sv
// Chosen here: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - build option: sub clock or sysclk/4
// - build option: crystal or rc sub clock
// - select bits set 256..32768 period timeout
// - bit 7 keeps sysclk in idle
// - disabled only if option and key 1010
// - control resets to 0x7A
// - normal timeout: device reset, set flag
// - sleep/idle timeout: clear pc, sp, set flag
// - reset pin, clear, halt clear count
// - single style: one clear instruction clears
// - paired style: clear on alternation, or first after power-on/pin reset
// - disabled watchdog makes instructions no-ops
// - sysclk/4 source stops in sleep, idle-off
// - idle-off halt: clear, sub clock resumes
// - idle-on halt: clear, resumes either source
module wdtu_top #(
  parameter logic OPT_SRC_IS_SUB     = 1'b1,
  parameter logic OPT_SUB_IS_CRYSTAL = 1'b1,
  parameter logic OPT_CFG_ENABLE     = 1'b1,
  parameter logic OPT_PAIRED_STYLE   = 1'b0
) (
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // oscillator ticks and reset pin, asynchronous
  input  wire logic                low_crystal_osc,
  input  wire logic                low_rc_osc,
  input  wire logic                external_reset_pin_n,
  // processor core, same clock
  input  wire wdtu_pkg::wdtu_instr_t instr,
  input  wire wdtu_pkg::wdtu_mode_t  power_mode,
  // reset requests and state
  output wdtu_pkg::wdtu_reset_t    reset_req,
  output logic                     timeout_flag,
  output logic                     idle_sysclk_keep,
  output logic                     wdt_enabled
);

  // build options gathered
  wdtu_pkg::wdtu_opts_t opts;
  assign opts = '{src_is_sub:     OPT_SRC_IS_SUB,
                  sub_is_crystal: OPT_SUB_IS_CRYSTAL,
                  cfg_enable:     OPT_CFG_ENABLE,
                  paired_style:   OPT_PAIRED_STYLE};

  logic [7:0]          watchdog_control;
  logic [2:0]          timeout_select;
  logic [3:0]          software_disable_key;
  logic [wdtu_pkg::COUNT_W-1:0] count;
  logic [1:0]          sys_div;
  logic                last_was_second;
  logic                paired_seen;
  logic [2:0]          xtal_sync;
  logic [2:0]          rc_sync;
  logic [1:0]          rst_sync;
  logic                sub_clock;
  logic                sub_tick;
  logic                sys_tick;
  logic                src_tick;
  logic                src_running;
  logic                clear_instr;
  logic                clear_evt;
  logic                expire;
  logic                enabled;
  logic                wr_en;
  logic                rd_en;
  logic [31:0]         next_prdata;

  assign timeout_select       = watchdog_control[wdtu_pkg::TSEL_LSB +: 3];
  assign software_disable_key = watchdog_control[wdtu_pkg::KEY_LSB +: 4];

  // decode of the terminal count for a timeout select code
  function automatic logic [wdtu_pkg::COUNT_W-1:0] last_count(input logic [2:0] sel);
    logic [wdtu_pkg::COUNT_W:0] span;
    span = (wdtu_pkg::COUNT_W+1)'(1) << (wdtu_pkg::TIMEOUT_BASE_LOG2 + int'(sel));
    last_count = wdtu_pkg::COUNT_W'(span - (wdtu_pkg::COUNT_W+1)'(1));
  endfunction

  // enable decode: only option off plus key 1010 disables
  assign enabled = opts.cfg_enable
                 | (software_disable_key != wdtu_pkg::KEY_DISABLE);

  // crystal oscillator: two sync flops plus one history flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_sync <= 3'h0;
    end else begin
      xtal_sync <= {xtal_sync[1:0], low_crystal_osc};
    end
  end

  // rc oscillator: two sync flops plus one history flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_sync <= 3'h0;
    end else begin
      rc_sync <= {rc_sync[1:0], low_rc_osc};
    end
  end

  // reset pin: two sync flops, idle high so reset gives no false clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_sync <= 2'h3;
    end else begin
      rst_sync <= {rst_sync[0], external_reset_pin_n};
    end
  end

  // sub clock from crystal or rc oscillator, rising edge as tick
  assign sub_clock = opts.sub_is_crystal ? xtal_sync[1] : rc_sync[1];
  assign sub_tick  = opts.sub_is_crystal ? (xtal_sync[1] & ~xtal_sync[2])
                                         : (rc_sync[1] & ~rc_sync[2]);

  // sysclk divided by four, stops when instruction clock stops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_div <= 2'h0;
    end else if (src_running) begin
      sys_div <= sys_div + 2'h1;
    end
  end
  assign sys_tick = src_running && (sys_div == wdtu_pkg::SYS_DIV_LAST);

  // system source halts in sleep and in idle with clock off
  always_comb begin
    if (opts.src_is_sub) begin
      src_running = 1'b1;
    end else begin
      case (power_mode)
        wdtu_pkg::WDTU_MODE_SLEEP:    src_running = 1'b0;
        wdtu_pkg::WDTU_MODE_IDLE_OFF: src_running = 1'b0;
        wdtu_pkg::WDTU_MODE_IDLE_ON:  src_running = 1'b1;
        default:                      src_running = 1'b1;
      endcase
    end
  end

  // watchdog source clock selection
  assign src_tick = opts.src_is_sub ? sub_tick : sys_tick;

  // clear instruction acceptance, by style
  always_comb begin
    if (!opts.paired_style) begin
      clear_instr = instr.clear_single;
    end else if (instr.clear_first_of_pair) begin
      clear_instr = !paired_seen || last_was_second;
    end else if (instr.clear_second_of_pair) begin
      clear_instr = !paired_seen || !last_was_second;
    end else begin
      clear_instr = 1'b0;
    end
  end

  // reset pin low clears the count whatever the enable state
  logic pin_clear;
  logic sw_clear;
  assign pin_clear = !rst_sync[1];

  // clear and halt only act while enabled, else no-ops
  assign sw_clear = enabled && (clear_instr || instr.halt);

  // any clear event
  assign clear_evt = pin_clear || sw_clear;

  assign expire = enabled && src_tick && !clear_evt
                && (count == last_count(timeout_select));

  // first pair instruction after power-on or pin reset is taken either way; a timeout reset keeps the history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      paired_seen <= 1'b0;
    end else if (pin_clear) begin
      paired_seen <= 1'b0;
    end else if (opts.paired_style && enabled && clear_instr) begin
      paired_seen <= 1'b1;
    end
  end

  // which half of the pair was taken last
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_was_second <= 1'b0;
    end else if (pin_clear) begin
      last_was_second <= 1'b0;
    end else if (opts.paired_style && enabled && clear_instr) begin
      last_was_second <= instr.clear_second_of_pair;
    end
  end

  // divider count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (clear_evt || expire || !enabled) begin
      count <= '0;
    end else if (src_tick) begin
      count <= count + wdtu_pkg::COUNT_W'(1);
    end
  end

  // reset request pulses, one cycle for each timeout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_req <= '0;
    end else begin
      reset_req.device_reset <= expire
                              && (power_mode == wdtu_pkg::WDTU_MODE_NORMAL);
      reset_req.pc_sp_clear  <= expire
                              && (power_mode != wdtu_pkg::WDTU_MODE_NORMAL);
    end
  end

  // sticky timeout flag, write one to clear; a timeout wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag <= 1'b0;
    end else if (expire) begin
      timeout_flag <= 1'b1;
    end else if (wr_en && paddr == wdtu_pkg::ADDR_STATUS
                 && pwdata[wdtu_pkg::BIT_TIMEOUT]) begin
      timeout_flag <= 1'b0;
    end
  end

  // apb strobes, zero wait state
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // control register; reset pin restores the power-on value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_control <= wdtu_pkg::CONTROL_RESET;
    end else if (!rst_sync[1] || reset_req.device_reset) begin
      watchdog_control <= wdtu_pkg::CONTROL_RESET;
    end else if (wr_en && paddr == wdtu_pkg::ADDR_CONTROL) begin
      watchdog_control <= pwdata[7:0];
    end
  end

  // read mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      wdtu_pkg::ADDR_CONTROL: next_prdata[7:0] = watchdog_control;
      wdtu_pkg::ADDR_STATUS: begin
        next_prdata[wdtu_pkg::BIT_TIMEOUT]   = timeout_flag;
        next_prdata[wdtu_pkg::BIT_ENABLED]   = enabled;
        next_prdata[wdtu_pkg::BIT_LAST_PAIR] = last_was_second;
      end
      wdtu_pkg::ADDR_COUNT: next_prdata[wdtu_pkg::COUNT_W-1:0] = count;
      default:              next_prdata = 32'h0000_0000;
    endcase
  end

  // true for the three mapped register addresses
  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = (addr == wdtu_pkg::ADDR_CONTROL)
                  || (addr == wdtu_pkg::ADDR_STATUS)
                  || (addr == wdtu_pkg::ADDR_COUNT);
  endfunction

  // ready for one cycle after every setup, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // error beside ready for an unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !addr_mapped(paddr);
    end
  end

  // read data captured at setup, held until the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= next_prdata;
    end
  end

  // idle clock keep bit, registered copy of control bit 7
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_sysclk_keep <= 1'b0;
    end else begin
      idle_sysclk_keep <= watchdog_control[wdtu_pkg::BIT_IDLE_KEEP];
    end
  end

  // enable state, registered for the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_enabled <= 1'b0;
    end else begin
      wdt_enabled <= enabled;
    end
  end

  logic unused_sub;
  assign unused_sub = sub_clock;

endmodule

`default_nettype wire

//--- test/wdtu_monitor.sv
`timescale 1ns/10ps
`default_nettype none

module wdtu_monitor (
  // clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // apb
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic [7:0]            paddr,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // core side
  input wire wdtu_pkg::wdtu_mode_t  power_mode,
  input wire wdtu_pkg::wdtu_reset_t reset_req,
  input wire logic                  timeout_flag,
  input wire logic                  wdt_enabled
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // apb handshake
  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held");
  map_error_a: assert property (pslverr |-> !(paddr inside {8'h00, 8'h04, 8'h08}))
    else $error("error on mapped place");
  // timeout consequences
  normal_reset_a: assert property (reset_req.device_reset |-> $past(power_mode) == 2'b00)
    else $error("device reset outside normal mode");
  sleep_clear_a: assert property (reset_req.pc_sp_clear |-> $past(power_mode) != 2'b00)
    else $error("pc clear in normal mode");
  flag_set_a: assert property (|reset_req |-> timeout_flag)
    else $error("timeout without flag");
  one_shot_a: assert property (|reset_req |=> reset_req == 2'b00)
    else $error("reset request held");
  live_only_a: assert property (|reset_req |-> $past(wdt_enabled))
    else $error("timeout while disabled");
  // main scenarios
  hit_reset_c: cover property (reset_req.device_reset);
  hit_clear_c: cover property (reset_req.pc_sp_clear);
  hit_error_c: cover property (pslverr);
endmodule

bind wdtu_top wdtu_monitor wdtu_monitor_i (.pclk, .presetn, .psel, .penable, .paddr, .pready,
  .pslverr, .power_mode, .reset_req, .timeout_flag, .wdt_enabled);
`default_nettype wire

//--- test/wdtu_core.sv
`timescale 1ns/10ps
`default_nettype none

module wdtu_core (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // bench requests
  input  wire logic [3:0]           op_req,
  input  wire wdtu_pkg::wdtu_mode_t mode_req,
  // toward the watchdog
  output wdtu_pkg::wdtu_instr_t     instr,
  output wdtu_pkg::wdtu_mode_t      power_mode,
  output logic                      xtal
);
  logic [1:0] div;

  // one retired instruction per request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr <= '0;
      power_mode <= wdtu_pkg::WDTU_MODE_NORMAL;
    end else begin
      instr <= wdtu_pkg::wdtu_instr_t'(op_req);
      power_mode <= mode_req;
    end
  end

  // crystal at a quarter of pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 2'h0;
    end else begin
      div <= div + 2'h1;
    end
  end
  assign xtal = div[1];
endmodule
`default_nettype wire

//--- test/tb_wdtu_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_wdtu_top;
  logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, xtal, pin_n;
  logic                  err, timeout_flag, idle_sysclk_keep, wdt_enabled;
  logic [7:0]            paddr, lfsr;
  logic [31:0]           pwdata, prdata, rd, prdata2, rd2;
  logic                  en2;
  logic [3:0]            op;
  wdtu_pkg::wdtu_mode_t  mreq, power_mode;
  wdtu_pkg::wdtu_instr_t instr;
  wdtu_pkg::wdtu_reset_t reset_req;
  int                    n_fail, checks_done, ctl, t;

  wdtu_top #(.OPT_CFG_ENABLE(1'b0)) wdtu_top_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .low_crystal_osc(xtal), .low_rc_osc(1'b0),
    .external_reset_pin_n(pin_n), .instr, .power_mode, .reset_req, .timeout_flag,
    .idle_sysclk_keep, .wdt_enabled);
  // second build: system clock source, paired clear style, option enabled
  wdtu_top #(.OPT_SRC_IS_SUB(1'b0), .OPT_SUB_IS_CRYSTAL(1'b0), .OPT_PAIRED_STYLE(1'b1))
    wdtu_top_i2 (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata(prdata2), .pready(), .pslverr(), .low_crystal_osc(xtal), .low_rc_osc(1'b0),
    .external_reset_pin_n(pin_n), .instr, .power_mode, .reset_req(), .timeout_flag(),
    .idle_sysclk_keep(), .wdt_enabled(en2));
  wdtu_core wdtu_core_i (.pclk, .presetn, .op_req(op), .mode_req(mreq), .instr, .power_mode,
    .xtal);

  // clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, s, x);
    end
  endtask

  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    rd2 = prdata2;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic issue(input logic [3:0] o, input wdtu_pkg::wdtu_mode_t m);
    @(posedge pclk);
    op <= o;
    mreq <= m;
    @(posedge pclk);
    op <= 4'h0;
  endtask

  task automatic wait_to(output int n);
    n = 0;
    while (reset_req === 2'b00) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    give_verdict();
  end

  // tests
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    op = 4'h0;
    mreq = wdtu_pkg::WDTU_MODE_NORMAL;
    pin_n = 1'b1;
    lfsr = 8'h47;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h7A);
    chk(wdt_enabled, 1'b0);
    issue(4'h8, wdtu_pkg::WDTU_MODE_NORMAL);
    repeat (40) @(posedge pclk);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk(err, 1'b1);
    $display("reset test done");
    chk(en2, 1'b1);
    issue(4'h4, wdtu_pkg::WDTU_MODE_NORMAL);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd2 < 2, 1'b1);
    repeat (40) @(posedge pclk);
    issue(4'h4, wdtu_pkg::WDTU_MODE_NORMAL);
    issue(4'h8, wdtu_pkg::WDTU_MODE_NORMAL);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd2 > 8, 1'b1);
    issue(4'h2, wdtu_pkg::WDTU_MODE_SLEEP);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd2 < 2, 1'b1);
    repeat (40) @(posedge pclk);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd2, 32'h0);
    issue(4'h0, wdtu_pkg::WDTU_MODE_NORMAL);
    repeat (40) @(posedge pclk);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd2 > 5, 1'b1);
    $display("paired and system source done");
    lfsr = nxt(lfsr);
    ctl = {24'h0, lfsr[7], 7'h05};
    apb(1'b1, 8'h00, ctl);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, ctl);
    chk(idle_sysclk_keep, lfsr[7]);
    chk(wdt_enabled, 1'b1);
    wait_to(t);
    chk(reset_req, 2'h2);
    chk(timeout_flag, 1'b1);
    chk(t > 1000 && t < 1040, 1'b1);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h7A);
    $display("normal timeout done");
    apb(1'b1, 8'h00, ctl);
    lfsr = nxt(lfsr);
    repeat (200 + lfsr) @(posedge pclk);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd > 40, 1'b1);
    issue(4'h8, wdtu_pkg::WDTU_MODE_NORMAL);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd < 2, 1'b1);
    for (int m = 1; m < 4; m++) begin
      repeat (300) @(posedge pclk);
      issue(4'h1, wdtu_pkg::wdtu_mode_t'(m));
      apb(1'b0, 8'h08, 32'h0);
      chk(rd < 2, 1'b1);
      wait_to(t);
      chk(reset_req, 2'h1);
      chk(t > 1000 && t < 1040, 1'b1);
      apb(1'b1, 8'h04, 32'h1);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd[1:0], 2'h2);
      issue(4'h0, wdtu_pkg::WDTU_MODE_NORMAL);
      $display("mode %0d done", m);
    end
    pin_n <= 1'b0;
    repeat (4) @(posedge pclk);
    pin_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h7A);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    $display("reset pin done");
    give_verdict();
  end
endmodule
`default_nettype wire
